/* rtl/dspalu_map.svh */
// Constants for the signal processor arithmetic datapath
`ifndef DSPALU_MAP_SVH
`define DSPALU_MAP_SVH
`define DSPALU_ACC_RESET    32'h0000_0000
`define DSPALU_PROD_RESET   32'h0000_0000
`define DSPALU_LATCH_RESET  16'h0000
`define DSPALU_SXM_RESET    1'b1
`define DSPALU_SHIFT_MAX    5'h10
`define DSPALU_PSHIFT_NONE  2'h0
`define DSPALU_PSHIFT_L1    2'h1
`define DSPALU_PSHIFT_L4    2'h2
`define DSPALU_PSHIFT_R6    2'h3
`endif

/* rtl/dspalu_pkg.sv */
// Types for the signal processor arithmetic datapath
package dspalu_pkg;
  typedef enum logic [3:0] {
    DSPALU_OP_NOP    = 4'h0,
    DSPALU_OP_LOAD   = 4'h1,
    DSPALU_OP_ADD    = 4'h2,
    DSPALU_OP_SUB    = 4'h3,
    DSPALU_OP_AND    = 4'h4,
    DSPALU_OP_OR     = 4'h5,
    DSPALU_OP_XOR    = 4'h6,
    DSPALU_OP_NORM   = 4'h7,
    DSPALU_OP_MAC    = 4'h8,
    DSPALU_OP_STHI   = 4'h9,
    DSPALU_OP_STLO   = 4'ha,
    DSPALU_OP_BIT    = 4'hb,
    DSPALU_OP_LDLAT  = 4'hc,
    DSPALU_OP_MPY    = 4'hd,
    DSPALU_OP_PMOVE  = 4'he,
    DSPALU_OP_BRACC  = 4'hf
  } dspalu_op_t;

  typedef enum logic [1:0] {
    DSPALU_ST_IDLE = 2'b00,
    DSPALU_ST_EXEC = 2'b01
  } dspalu_state_t;

  typedef struct packed {
    logic        valid;
    dspalu_op_t  op;
    logic [4:0]  shift;
    logic        use_prod;
    logic        mul_signed;
    logic [3:0]  bit_sel;
    logic [2:0]  store_shift;
  } dspalu_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } dspalu_word_t;
endpackage

/* rtl/dspalu_scaler.sv */
// Input scaling shifter: 16-bit bus word to 32-bit ALU operand
`timescale 1ns/1ps
`include "dspalu_map.svh"
module dspalu_scaler (
  input  wire logic [15:0] data_i,
  input  wire logic [4:0]  shift_i,
  input  wire logic        sign_extend_select_i,
  output logic      [31:0] result_o
);
  wire [31:0] widened;
  wire [4:0]  amount;
  assign widened  = {{16{sign_extend_select_i & data_i[15]}}, data_i};
  assign amount   = (shift_i > `DSPALU_SHIFT_MAX) ? `DSPALU_SHIFT_MAX : shift_i;
  assign result_o = widened << amount;
endmodule // dspalu_scaler

/* rtl/dspalu_core.sv */
// Arithmetic datapath: ALU, accumulator, multiplier, shifters
//
// Overview of operation
// - 32-bit ALU and accumulator, single-cycle ops
// - ALU operands: accumulator plus product or scaler
// - ALU result written back into accumulator
// - Accumulator stored as upper and lower halves
// - Store path shifts; accumulator left untouched
// - Branch target taken from accumulator
// - Normalize accumulator by removing sign bits
// - Test selected memory bit for branching
// - Scaler widens 16-bit bus word to 32
// - Scaler left shift 0 to 16 from instruction
// - Vacated low bits of scaler fill zero
// - Scaler upper bits follow sign-extend select
// - 16x16 multiply, signed or unsigned, one cycle
// - Operand latch holds one multiplier input
// - Product register captures result, feeds ALU
// - Multiply-accumulate takes program and data words
// - Four product shift modes before ALU
// - Program words movable into data space
`timescale 1ns/1ps
`include "dspalu_map.svh"
module dspalu_core (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire dspalu_pkg::dspalu_cmd_t  cmd_i,
  input  wire dspalu_pkg::dspalu_word_t data_bus_i,
  input  wire dspalu_pkg::dspalu_word_t prog_bus_i,
  input  wire logic                 sign_extend_select_i,
  input  wire logic [1:0]           prod_shift_mode_i,
  output dspalu_pkg::dspalu_word_t  data_bus_o,
  output logic      [15:0]          branch_target_o,
  output logic                      branch_take_o,
  output logic                      bit_test_o,
  output logic      [31:0]          accumulator_o,
  output logic      [31:0]          product_holding_register_o,
  output logic      [15:0]          multiplier_operand_latch_o,
  output logic                      busy_o
);
  import dspalu_pkg::*;

  logic [31:0]   acc_reg;
  logic [31:0]   acc_next;
  logic [31:0]   prod_reg;
  logic [31:0]   prod_next;
  logic [15:0]   latch_reg;
  logic [15:0]   latch_next;
  dspalu_word_t  dout_reg;
  dspalu_word_t  dout_next;
  logic [15:0]   target_reg;
  logic          branch_reg;
  logic          bit_reg;
  logic          bit_next;
  dspalu_state_t state_reg;

  wire        go;
  wire [31:0] scaled;
  wire [31:0] prod_shifted;
  wire [31:0] operand_b;
  wire [31:0] sum;
  wire [31:0] diff;
  wire [16:0] mul_a;
  wire [16:0] mul_b;
  wire [33:0] mul_full;
  wire [15:0] mul_src;
  wire [31:0] norm_shift;
  wire        norm_needed;
  wire [31:0] store_word;
  wire        is_mul;
  wire        is_mac;
  wire        writes_acc;
  wire        is_store;

  assign go = cmd_i.valid;

  dspalu_scaler u_scaler (
    .data_i               (data_bus_i.data),
    .shift_i              (cmd_i.shift),
    .sign_extend_select_i (sign_extend_select_i),
    .result_o             (scaled)
  );

  // Product shift modes: 0 none, 1 left 1, 2 left 4, 3 right 6 arithmetic
  assign prod_shifted = (prod_shift_mode_i == `DSPALU_PSHIFT_L1) ? (prod_reg << 1) :
                        (prod_shift_mode_i == `DSPALU_PSHIFT_L4) ? (prod_reg << 4) :
                        (prod_shift_mode_i == `DSPALU_PSHIFT_R6) ?
                          32'($signed(prod_reg) >>> 6) : prod_reg;

  assign operand_b = (cmd_i.use_prod || cmd_i.op == DSPALU_OP_MAC) ? prod_shifted : scaled;
  assign sum       = acc_reg + operand_b;
  assign diff      = acc_reg - operand_b;

  // MAC multiplies the program-bus word by the data-bus word in one step
  assign is_mac  = (cmd_i.op == DSPALU_OP_MAC);
  assign is_mul  = (cmd_i.op == DSPALU_OP_MPY) || is_mac;
  assign mul_src = is_mac ? prog_bus_i.data : latch_reg;
  assign mul_a   = {cmd_i.mul_signed & mul_src[15], mul_src};
  assign mul_b   = {cmd_i.mul_signed & data_bus_i.data[15], data_bus_i.data};
  // Widen both operands first so the product keeps all 34 bits whatever the tool
  assign mul_full = {{17{mul_a[16]}}, mul_a} * {{17{mul_b[16]}}, mul_b};

  // Normalize one step: shift left once if the two top bits agree and the accumulator is not zero
  assign norm_needed = (acc_reg[31] == acc_reg[30]) && (acc_reg != 32'h0000_0000);
  assign norm_shift  = norm_needed ? (acc_reg << 1) : acc_reg;

  assign writes_acc = go && (cmd_i.op inside {DSPALU_OP_LOAD, DSPALU_OP_ADD, DSPALU_OP_SUB,
                      DSPALU_OP_AND, DSPALU_OP_OR, DSPALU_OP_XOR, DSPALU_OP_NORM, DSPALU_OP_MAC});
  assign is_store   = go && (cmd_i.op == DSPALU_OP_STHI || cmd_i.op == DSPALU_OP_STLO);
  assign store_word = acc_reg << cmd_i.store_shift;

  always_comb begin
    acc_next = acc_reg;
    if (writes_acc) begin
      case (cmd_i.op)
        DSPALU_OP_LOAD: acc_next = operand_b;
        DSPALU_OP_ADD:  acc_next = sum;
        DSPALU_OP_SUB:  acc_next = diff;
        DSPALU_OP_AND:  acc_next = acc_reg & operand_b;
        DSPALU_OP_OR:   acc_next = acc_reg | operand_b;
        DSPALU_OP_XOR:  acc_next = acc_reg ^ operand_b;
        DSPALU_OP_NORM: acc_next = norm_shift;
        DSPALU_OP_MAC:  acc_next = sum;
        default:        acc_next = acc_reg;
      endcase
    end
  end

  assign prod_next  = (go && is_mul) ? mul_full[31:0] : prod_reg;
  assign latch_next = (go && cmd_i.op == DSPALU_OP_LDLAT) ? data_bus_i.data : latch_reg;
  assign bit_next   = (go && cmd_i.op == DSPALU_OP_BIT) ?
                      data_bus_i.data[4'hf - cmd_i.bit_sel] : bit_reg;

  always_comb begin
    dout_next = '0;
    if (is_store) begin
      dout_next.valid = 1'b1;
      dout_next.data  = (cmd_i.op == DSPALU_OP_STHI) ? store_word[31:16]
                                                     : store_word[15:0];
    end else if (go && cmd_i.op == DSPALU_OP_PMOVE) begin
      dout_next.valid = prog_bus_i.valid;
      dout_next.data  = prog_bus_i.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_reg    <= `DSPALU_ACC_RESET;
      prod_reg   <= `DSPALU_PROD_RESET;
      latch_reg  <= `DSPALU_LATCH_RESET;
      dout_reg   <= '0;
      bit_reg    <= 1'b0;
      target_reg <= 16'h0000;
      branch_reg <= 1'b0;
      state_reg  <= DSPALU_ST_IDLE;
    end else begin
      acc_reg    <= acc_next;
      prod_reg   <= prod_next;
      latch_reg  <= latch_next;
      dout_reg   <= dout_next;
      bit_reg    <= bit_next;
      branch_reg <= go && (cmd_i.op == DSPALU_OP_BRACC);
      if (go && cmd_i.op == DSPALU_OP_BRACC) begin
        target_reg <= acc_reg[15:0];
      end
      case (state_reg)
        DSPALU_ST_IDLE: state_reg <= go ? DSPALU_ST_EXEC : DSPALU_ST_IDLE;
        DSPALU_ST_EXEC: state_reg <= go ? DSPALU_ST_EXEC : DSPALU_ST_IDLE;
        default:        state_reg <= DSPALU_ST_IDLE;
      endcase
    end
  end

  assign data_bus_o                 = dout_reg;
  assign branch_target_o            = target_reg;
  assign branch_take_o              = branch_reg;
  assign bit_test_o                 = bit_reg;
  assign accumulator_o              = acc_reg;
  assign product_holding_register_o = prod_reg;
  assign multiplier_operand_latch_o = latch_reg;
  assign busy_o                     = (state_reg == DSPALU_ST_EXEC);

  sequence s_add_cmd;
    go && cmd_i.op == DSPALU_OP_ADD;
  endsequence

  a_add_writeback: assert property (@(posedge clk_i) disable iff (reset_i)
    s_add_cmd |=> acc_reg == $past(acc_reg) + $past(operand_b))
    else $error("Add result not written to accumulator");
  a_store_keeps_acc: assert property (@(posedge clk_i) disable iff (reset_i)
    is_store |=> acc_reg == $past(acc_reg))
    else $error("Store changed the accumulator");
  a_store_half: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_STHI && cmd_i.store_shift == 3'h0)
      |=> data_bus_o.valid && data_bus_o.data == acc_reg[31:16])
    else $error("Upper store half wrong");
  a_branch_target: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_BRACC) |=> branch_take_o && branch_target_o == $past(acc_reg[15:0]))
    else $error("Branch target not from accumulator");
  a_mul_product: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_MPY && !cmd_i.mul_signed)
      |=> prod_reg == {16'h0000, $past(latch_reg)} * {16'h0000, $past(data_bus_i.data)})
    else $error("Unsigned product wrong");
  a_latch_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    !(go && cmd_i.op == DSPALU_OP_LDLAT) |=> latch_reg == $past(latch_reg))
    else $error("Operand latch changed without load");
  a_scaler_low_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (cmd_i.shift == 5'h10) |-> scaled[15:0] == 16'h0000)
    else $error("Scaler low bits not zero");
  a_scaler_zero_fill: assert property (@(posedge clk_i) disable iff (reset_i)
    (!sign_extend_select_i && cmd_i.shift == 5'h0) |-> scaled[31:16] == 16'h0000)
    else $error("Scaler upper bits not zero filled");
  a_pshift_left4: assert property (@(posedge clk_i) disable iff (reset_i)
    (prod_shift_mode_i == 2'h2) |-> prod_shifted == {prod_reg[27:0], 4'h0})
    else $error("Product shift mode two wrong");
  a_bit_test: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_BIT && cmd_i.bit_sel == 4'h0)
      |=> bit_test_o == $past(data_bus_i.data[15]))
    else $error("Bit test result wrong");

  sequence s_load_cmd;
    go && cmd_i.op == DSPALU_OP_LOAD;
  endsequence

  sequence s_mac_cmd;
    go && cmd_i.op == DSPALU_OP_MAC;
  endsequence

  sequence s_norm_cmd;
    go && cmd_i.op == DSPALU_OP_NORM;
  endsequence

  sequence s_pmove_cmd;
    go && cmd_i.op == DSPALU_OP_PMOVE;
  endsequence

  sequence s_idle_cycle;
    !go;
  endsequence

  // Busy follows command valid and branch take clears; the accumulator stands still on idle cycles, other state unless a command of its own kind arrives
  a_busy_follows: assert property (@(posedge clk_i) disable iff (reset_i)
    1'b1 |=> busy_o == $past(go))
    else $error("Busy does not follow command valid");
  a_idle_keeps_acc: assert property (@(posedge clk_i) disable iff (reset_i)
    s_idle_cycle |=> acc_reg == $past(acc_reg))
    else $error("Accumulator changed without a command");
  a_prod_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    !(go && is_mul) |=> prod_reg == $past(prod_reg))
    else $error("Product changed without a multiply");
  a_target_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    !(go && cmd_i.op == DSPALU_OP_BRACC)
      |=> !branch_take_o && branch_target_o == $past(branch_target_o))
    else $error("Branch outputs changed without a branch");
  a_bit_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    !(go && cmd_i.op == DSPALU_OP_BIT) |=> bit_test_o == $past(bit_test_o))
    else $error("Bit test outcome changed without a test");

  // Paths from the buses into the accumulator, operand latch and product register, plus normalize and product shifts
  a_load_zero_ext: assert property (@(posedge clk_i) disable iff (reset_i)
    s_load_cmd ##0 (!cmd_i.use_prod && !sign_extend_select_i && cmd_i.shift == 5'h00)
      |=> acc_reg == {16'h0000, $past(data_bus_i.data)})
    else $error("Load did not widen the bus word");
  a_scaler_sign_ext: assert property (@(posedge clk_i) disable iff (reset_i)
    (sign_extend_select_i && cmd_i.shift == 5'h00)
      |-> scaled == {{16{data_bus_i.data[15]}}, data_bus_i.data})
    else $error("Scaler upper bits not sign extended");
  a_scaler_clamp: assert property (@(posedge clk_i) disable iff (reset_i)
    (cmd_i.shift > 5'h10) |-> scaled == {data_bus_i.data, 16'h0000})
    else $error("Scaler shift not clamped to sixteen");
  a_prod_operand: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_ADD && cmd_i.use_prod && prod_shift_mode_i == 2'h0)
      |=> acc_reg == $past(acc_reg) + $past(prod_reg))
    else $error("Product not taken as second operand");
  a_ldlat_capture: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_LDLAT) |=> latch_reg == $past(data_bus_i.data))
    else $error("Operand latch did not capture the bus word");
  a_signed_product: assert property (@(posedge clk_i) disable iff (reset_i)
    (go && cmd_i.op == DSPALU_OP_MPY && cmd_i.mul_signed)
      |=> $signed(prod_reg) == $signed($past(latch_reg)) * $signed($past(data_bus_i.data)))
    else $error("Signed product wrong");
  a_mac_product: assert property (@(posedge clk_i) disable iff (reset_i)
    s_mac_cmd ##0 (!cmd_i.mul_signed)
      |=> prod_reg == {16'h0000, $past(prog_bus_i.data)} * {16'h0000, $past(data_bus_i.data)})
    else $error("Multiply-accumulate product wrong");
  a_mac_accumulate: assert property (@(posedge clk_i) disable iff (reset_i)
    s_mac_cmd |=> acc_reg == $past(acc_reg) + $past(prod_shifted))
    else $error("Multiply-accumulate sum wrong");
  a_norm_step: assert property (@(posedge clk_i) disable iff (reset_i)
    s_norm_cmd ##0 (acc_reg[31] == acc_reg[30] && acc_reg != 32'h0000_0000)
      |=> acc_reg == {$past(acc_reg[30:0]), 1'b0})
    else $error("Normalize step wrong");
  a_pshift_none: assert property (@(posedge clk_i) disable iff (reset_i)
    (prod_shift_mode_i == 2'h0) |-> prod_shifted == prod_reg)
    else $error("Product shift mode zero wrong");
  a_pshift_left1: assert property (@(posedge clk_i) disable iff (reset_i)
    (prod_shift_mode_i == 2'h1) |-> prod_shifted == {prod_reg[30:0], 1'b0})
    else $error("Product shift mode one wrong");
  a_pshift_right6: assert property (@(posedge clk_i) disable iff (reset_i)
    (prod_shift_mode_i == 2'h3) |-> prod_shifted == {{6{prod_reg[31]}}, prod_reg[31:6]})
    else $error("Product shift mode three wrong");

  // Store and move paths onto the outgoing data bus
  a_store_low: assert property (@(posedge clk_i) disable iff (reset_i)
    (is_store && cmd_i.op == DSPALU_OP_STLO)
      |=> data_bus_o.valid
          && data_bus_o.data == 16'($past(acc_reg) << $past(cmd_i.store_shift)))
    else $error("Lower store half wrong");
  a_store_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
    is_store ##1 s_idle_cycle |=> !data_bus_o.valid)
    else $error("Store valid held longer than one cycle");
  a_pmove_copy: assert property (@(posedge clk_i) disable iff (reset_i)
    s_pmove_cmd |=> data_bus_o.valid == $past(prog_bus_i.valid)
      && data_bus_o.data == $past(prog_bus_i.data))
    else $error("Program word not moved onto data bus");
endmodule // dspalu_core

/* test/dspalu_bus_model.sv */
// Decoder and memory bus model that feeds the arithmetic datapath
`timescale 1ns/1ps
module dspalu_bus_model (
  input  wire logic                    clk_i,
  input  wire dspalu_pkg::dspalu_cmd_t cmd_i,
  input  wire logic [15:0]             data_i,
  input  wire logic [15:0]             prog_i,
  output dspalu_pkg::dspalu_cmd_t      cmd_o,
  output dspalu_pkg::dspalu_word_t     data_bus_o,
  output dspalu_pkg::dspalu_word_t     prog_bus_o
);
  import dspalu_pkg::*;
  logic [15:0] dlast_reg = 16'h0000;
  logic [15:0] plast_reg = 16'h0000;
  assign cmd_o = cmd_i;
  // Both words ride in the cycle of their command; idle buses show the inverted last word
  assign data_bus_o = '{cmd_i.valid, cmd_i.valid ? data_i : ~dlast_reg};
  assign prog_bus_o = '{cmd_i.valid, cmd_i.valid ? prog_i : ~plast_reg};
  always @(posedge clk_i) begin
    if (cmd_i.valid) begin
      dlast_reg <= data_i;
      plast_reg <= prog_i;
    end
  end
endmodule // dspalu_bus_model

/* test/tb_dsp_alu_shifter_multiplier.sv */
// Self-checking bench for the arithmetic datapath
`timescale 1ns/1ps
module tb_dsp_alu_shifter_multiplier;
  import dspalu_pkg::*;
  typedef struct packed {
    dspalu_op_t  op;
    logic [4:0]  sh;
    logic        up;
    logic        ms;
    logic [3:0]  bs;
    logic [2:0]  ss;
    logic        sx;
    logic [1:0]  pm;
    logic [15:0] d;
    logic [15:0] p;
  } dspalu_row_t;
  logic         clk_i = 1'b0;
  logic         reset_i = 1'b1;
  dspalu_cmd_t  cmd = '0;
  logic [15:0]  dw = 16'h0000;
  logic [15:0]  pw = 16'h0000;
  logic         sx_sel = 1'b0;
  logic [1:0]   pmode = 2'h0;
  dspalu_cmd_t  cmd_w;
  dspalu_word_t dbus, pbus, dout;
  logic [15:0]  btgt, latch, e_lat, e_tgt, e_dd;
  logic [31:0]  acc, prod, e_acc, e_prod;
  logic         btake, btst, busy, e_bt, e_busy, e_dv, e_take;
  int           fail_count = 0;
  int           compares = 0;
  int           cycles = 0;
  dspalu_row_t  rows [26] = '{
    '{DSPALU_OP_LOAD,5'h04,0,0,0,0,1,0,16'h8001,0}, '{DSPALU_OP_LOAD,5'h10,0,0,0,0,0,0,16'h8001,0},
    '{DSPALU_OP_LOAD,5'h14,0,0,0,0,1,0,16'h0003,0}, '{DSPALU_OP_ADD,5'h00,0,0,0,0,1,0,16'hffff,0},
    '{DSPALU_OP_SUB,5'h01,0,0,0,0,0,0,16'h0002,0}, '{DSPALU_OP_AND,5'h08,0,0,0,0,0,0,16'hf0f0,0},
    '{DSPALU_OP_OR,5'h02,0,0,0,0,0,0,16'h0a0a,0}, '{DSPALU_OP_XOR,5'h00,0,0,0,0,1,0,16'hffff,0},
    '{DSPALU_OP_LDLAT,5'h00,0,0,0,0,0,0,16'hfffd,0}, '{DSPALU_OP_MPY,5'h00,0,1,0,0,0,0,16'h0005,0},
    '{DSPALU_OP_ADD,5'h00,1,0,0,0,0,3,16'h0000,0}, '{DSPALU_OP_SUB,5'h00,1,0,0,0,0,2,16'h0000,0},
    '{DSPALU_OP_ADD,5'h00,1,0,0,0,0,0,16'h0000,0}, '{DSPALU_OP_MAC,5'h00,0,0,0,0,0,1,16'h0003,7},
    '{DSPALU_OP_MPY,5'h00,0,0,0,0,0,0,16'h8000,0}, '{DSPALU_OP_STHI,5'h00,0,0,0,4,0,0,16'h0000,0},
    '{DSPALU_OP_STLO,5'h00,0,0,0,7,0,0,16'h0000,0}, '{DSPALU_OP_LOAD,5'h00,0,0,0,0,0,0,16'h0001,0},
    '{DSPALU_OP_NORM,5'h00,0,0,0,0,0,0,16'h0000,0}, '{DSPALU_OP_NORM,5'h00,0,0,0,0,0,0,16'h0000,0},
    '{DSPALU_OP_BIT,5'h00,0,0,0,0,0,0,16'h8000,0}, '{DSPALU_OP_BIT,5'h00,0,0,15,0,0,0,16'h0001,0},
    '{DSPALU_OP_BIT,5'h00,0,0,3,0,0,0,16'hefff,0}, '{DSPALU_OP_PMOVE,5'h00,0,0,0,0,0,0,0,16'ha55a},
    '{DSPALU_OP_BRACC,5'h00,0,0,0,0,0,0,0,0}, '{DSPALU_OP_NOP,5'h00,0,0,0,0,0,0,16'h1234,0}};

  dspalu_bus_model i_model (.clk_i(clk_i), .cmd_i(cmd), .data_i(dw), .prog_i(pw),
    .cmd_o(cmd_w), .data_bus_o(dbus), .prog_bus_o(pbus));
  dspalu_core i_dut (.clk_i(clk_i), .reset_i(reset_i), .cmd_i(cmd_w), .data_bus_i(dbus),
    .prog_bus_i(pbus), .sign_extend_select_i(sx_sel), .prod_shift_mode_i(pmode),
    .data_bus_o(dout), .branch_target_o(btgt), .branch_take_o(btake), .bit_test_o(btst),
    .accumulator_o(acc), .product_holding_register_o(prod),
    .multiplier_operand_latch_o(latch), .busy_o(busy));

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fail_count++;
      test_done();
    end
  end

  function automatic logic [31:0] ext(logic [15:0] v, logic s);
    return s ? {{16{v[15]}}, v} : {16'h0000, v};
  endfunction
  function automatic logic [31:0] pshift(logic [31:0] v, logic [1:0] m);
    case (m)
      2'h1: return v << 1;
      2'h2: return v << 4;
      2'h3: return $signed(v) >>> 6;
      default: return v;
    endcase
  endfunction
  task automatic clear_exp();
    {e_acc, e_prod, e_lat, e_tgt} = '0;
    {e_bt, e_busy, e_dv, e_take} = '0;
  endtask
  task automatic model(dspalu_row_t r);
    logic [31:0] b;
    logic [31:0] s;
    s = ext(r.d, r.sx) << ((r.sh > 5'h10) ? 5'h10 : r.sh);
    b = (r.up || r.op == DSPALU_OP_MAC) ? pshift(e_prod, r.pm) : s;
    {e_dv, e_take, e_busy} = 3'h1;
    case (r.op)
      DSPALU_OP_LOAD: e_acc = b;
      DSPALU_OP_ADD: e_acc = e_acc + b;
      DSPALU_OP_SUB: e_acc = e_acc - b;
      DSPALU_OP_AND: e_acc = e_acc & b;
      DSPALU_OP_OR: e_acc = e_acc | b;
      DSPALU_OP_XOR: e_acc = e_acc ^ b;
      DSPALU_OP_NORM: e_acc = (e_acc[31] == e_acc[30] && e_acc != 0) ? e_acc << 1 : e_acc;
      DSPALU_OP_MAC: {e_acc, e_prod} = {e_acc + b, ext(r.p, r.ms) * ext(r.d, r.ms)};
      DSPALU_OP_STHI: {e_dv, e_dd} = {1'b1, 16'((e_acc << r.ss) >> 16)};
      DSPALU_OP_STLO: {e_dv, e_dd} = {1'b1, 16'(e_acc << r.ss)};
      DSPALU_OP_BIT: e_bt = r.d[4'hf - r.bs];
      DSPALU_OP_LDLAT: e_lat = r.d;
      DSPALU_OP_MPY: e_prod = ext(e_lat, r.ms) * ext(r.d, r.ms);
      DSPALU_OP_PMOVE: {e_dv, e_dd} = {1'b1, r.p};
      DSPALU_OP_BRACC: {e_take, e_tgt} = {1'b1, e_acc[15:0]};
      default: ;
    endcase
  endtask
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(logic got, logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic check();
    cmp(acc, e_acc);
    cmp(prod, e_prod);
    cmp(latch, e_lat);
    cmp_flag(dout.valid, e_dv);
    if (e_dv) cmp(dout.data, e_dd);
    cmp_flag(btake, e_take);
    cmp(btgt, e_tgt);
    cmp_flag(btst, e_bt);
    cmp_flag(busy, e_busy);
  endtask
  task automatic issue(dspalu_row_t r, logic v);
    @(posedge clk_i);
    cmd <= '{v, r.op, r.sh, r.up, r.ms, r.bs, r.ss};
    dw <= r.d;
    pw <= r.p;
    sx_sel <= r.sx;
    pmode <= r.pm;
    #1;
    check();
    if (v) model(r);
    else {e_dv, e_take, e_busy} = 3'h0;
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    clear_exp();
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    check();
    foreach (rows[i]) issue(rows[i], 1'b1);
    issue(rows[25], 1'b0);
    issue(rows[15], 1'b1);
    issue(dspalu_row_t'{DSPALU_OP_STHI, 5'h00, 0, 0, 0, 0, 0, 0, 16'h0000, 0}, 1'b1);
    issue(rows[0], 1'b0);
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    clear_exp();
    check();
    issue(rows[3], 1'b1);
    issue(rows[0], 1'b0);
    test_done();
  end
endmodule // tb_dsp_alu_shifter_multiplier
